// file: rtl/dkc_regs.svh
// Status bit positions, reset value, command codes and drive count of the command/error block
`ifndef DKC_REGS_SVH
`define DKC_REGS_SVH

`define DKC_ST_OPI_BIT     4'hA
`define DKC_ST_CRC_BIT     4'hB
`define DKC_ST_LATE_BIT    4'hC
`define DKC_ST_NXM_BIT     4'hD
`define DKC_ST_DRVERR_BIT  4'hE
`define DKC_ST_ERRSUM_BIT  4'hF
`define DKC_ST_RESET       16'h0080
`define DKC_CMD_SEEK       3'h3
`define DKC_CMD_GETSTAT    3'h2
`define DKC_CMD_MAINT      3'h0
`define DKC_NDRIVES        4

`endif

// file: rtl/dkc_pkg.sv
// Types shared by the command/error block
package dkc_pkg;

  typedef enum logic [1:0] {
    DKC_IDLE = 2'b00,
    DKC_BUSY = 2'b01,
    DKC_DONE = 2'b11
  } dkc_state_t;

  // Error events reported by the datapath for the running command
  typedef struct packed {
    logic op_incomplete;
    logic data_check;
    logic header_check;
    logic data_late;
    logic header_missing;
    logic no_memory;
    logic parity_abort;
    logic drive_err;
  } dkc_err_t;

  // A command issued by the host
  typedef struct packed {
    logic [2:0] func;
    logic [1:0] drive;
  } dkc_cmd_t;

endpackage

// file: rtl/dkc_cmd_status.sv
// Command sequencing, completion and controller error status
//
// Behaviour
// - Operation incomplete sets status bit 10 and summary bit 15.
// - Data or header check mismatch sets status bit 11.
// - Data late sets bit 12; missing header sets bits 10 and 12.
// - Nonexistent memory on bus access sets status bit 13.
// - Parity abort ends a non-seek command and sets bits 10 and 13.
// - Drive error sets bit 14; host then requests drive status.
// - Seek handed to drive sets ready and interrupts immediately.
// - Seek completion raises no interrupt; only drive ready shows it.
// - New seek to another drive accepted while earlier drives seek.
// - Transfer end signalled by interrupt and ready; host checks errors.
`timescale 1ns/1ps
`include "dkc_regs.svh"

module dkc_cmd_status #(
  parameter int NDRIVES = `DKC_NDRIVES
) (
  input  wire logic              sys_clk_i,        // 40 MHz clock
  input  wire logic              rst_i,            // Async reset, active high
  input  wire logic              cmd_go_i,         // Host issues command (pulse)
  input  dkc_pkg::dkc_cmd_t      cmd_i,            // Function and drive select
  input  wire logic              int_enable_i,     // Interrupt enable
  input  wire logic              seek_sent_i,      // Seek passed to drive (pulse)
  input  wire logic              xfer_done_i,      // Non-seek operation ended (pulse)
  input  dkc_pkg::dkc_err_t      err_i,            // Error events (pulses)
  input  wire logic [NDRIVES-1:0] drv_ready_i,     // Per-drive ready level
  output logic [15:0]            status_o,         // Controller error status bits
  output logic                   ctrl_ready_o,     // Controller ready flag
  output logic                   drive_ready_o,    // Selected drive ready
  output logic                   irq_o,            // Interrupt pulse
  output logic                   busy_o            // Command in progress
);

  dkc_pkg::dkc_state_t st_r, st_nxt;
  logic [15:0]         status_r, status_nxt;
  logic                irq_r, irq_nxt;
  logic                drive_ready_flag_r, drive_ready_flag_nxt;
  logic [1:0]          drive_r, drive_nxt;
  logic                seek_r, seek_nxt;
  logic                ready_r, ready_nxt;
  logic                busy_r, busy_nxt;
  logic                err_any;
  logic                abort;

  assign err_any = |err_i;
  // Parity abort ends a non-seek command at once; a seek ignores it
  assign abort = err_i.parity_abort;

  // Command sequencer and status flags
  always_comb begin
    st_nxt     = st_r;
    status_nxt = status_r;
    irq_nxt    = 1'b0;
    drive_nxt  = drive_r;
    seek_nxt   = seek_r;
    case (st_r)
      dkc_pkg::DKC_IDLE, dkc_pkg::DKC_DONE: begin
        // Apart from reset, only a new command wipes the logged errors
        if (cmd_go_i) begin
          status_nxt = 16'h0000;
          drive_nxt  = cmd_i.drive;
          seek_nxt   = (cmd_i.func == `DKC_CMD_SEEK);
          st_nxt     = dkc_pkg::DKC_BUSY;
        end
      end
      dkc_pkg::DKC_BUSY: begin
        // Seek completes toward the host once handed over, not at head arrival
        if (seek_r && seek_sent_i) begin
          st_nxt  = dkc_pkg::DKC_DONE;
          irq_nxt = int_enable_i;
        end else if (!seek_r && (xfer_done_i || abort)) begin
          st_nxt  = dkc_pkg::DKC_DONE;
          irq_nxt = int_enable_i;
        end
      end
      default: st_nxt = dkc_pkg::DKC_IDLE;
    endcase
    // Error events accumulate while busy; set wins since nothing clears here
    if (st_r == dkc_pkg::DKC_BUSY) begin
      if (err_i.op_incomplete)
        status_nxt[`DKC_ST_OPI_BIT] = 1'b1;
      if (err_i.data_check || err_i.header_check)
        status_nxt[`DKC_ST_CRC_BIT] = 1'b1;
      if (err_i.data_late)
        status_nxt[`DKC_ST_LATE_BIT] = 1'b1;
      if (err_i.header_missing) begin
        status_nxt[`DKC_ST_OPI_BIT]  = 1'b1;
        status_nxt[`DKC_ST_LATE_BIT] = 1'b1;
      end
      if (err_i.no_memory)
        status_nxt[`DKC_ST_NXM_BIT] = 1'b1;
      if (err_i.parity_abort) begin
        status_nxt[`DKC_ST_OPI_BIT] = 1'b1;
        status_nxt[`DKC_ST_NXM_BIT] = 1'b1;
      end
      if (err_i.drive_err)
        status_nxt[`DKC_ST_DRVERR_BIT] = 1'b1;
      if (err_any)
        status_nxt[`DKC_ST_ERRSUM_BIT] = 1'b1;
    end
  end

  // Drive ready follows the selected drive; its rise never interrupts
  always_comb begin
    drive_ready_flag_nxt = drv_ready_i[drive_r];
  end

  // Ready and busy are taken from the next state so they leave a flop
  // in the same cycle as the state itself; this keeps the outputs glitch free
  always_comb begin
    ready_nxt = (st_nxt != dkc_pkg::DKC_BUSY);
    busy_nxt  = (st_nxt == dkc_pkg::DKC_BUSY);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r     <= dkc_pkg::DKC_IDLE;
      status_r <= `DKC_ST_RESET;
      irq_r    <= 1'b0;
      drive_ready_flag_r   <= 1'b0;
      drive_r  <= 2'h0;
      seek_r   <= 1'b0;
      ready_r  <= 1'b1;
      busy_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      status_r <= status_nxt;
      irq_r    <= irq_nxt;
      drive_ready_flag_r   <= drive_ready_flag_nxt;
      drive_r  <= drive_nxt;
      seek_r   <= seek_nxt;
      ready_r  <= ready_nxt;
      busy_r   <= busy_nxt;
    end
  end

  // Outputs straight from flip-flops; bit 7 mirrors controller ready
  always_comb begin
    status_o      = {status_r[15:8], ready_r, status_r[6:0]};
    ctrl_ready_o  = ready_r;
    drive_ready_o = drive_ready_flag_r;
    irq_o         = irq_r;
    busy_o        = busy_r;
  end

endmodule

// file: test/dkc_cmd_status_assertions.sv
// Port-level checker for the command/error status block
`timescale 1ns/1ps
module dkc_cmd_status_assertions #(parameter int NDRIVES = 4) (
  input wire logic               sys_clk_i,     // Clock
  input wire logic               rst_i,         // Reset
  input wire logic               cmd_go_i,      // Issue
  input dkc_pkg::dkc_cmd_t       cmd_i,         // Command
  input wire logic               int_enable_i,  // Irq enable
  input wire logic               seek_sent_i,   // Seek handed over
  input wire logic               xfer_done_i,   // Transfer end
  input dkc_pkg::dkc_err_t       err_i,         // Error events
  input wire logic [NDRIVES-1:0] drv_ready_i,   // Drive ready
  input wire logic [15:0]        status_o,      // Status
  input wire logic               ctrl_ready_o,  // Ready
  input wire logic               drive_ready_o, // Drive ready out
  input wire logic               irq_o,         // Interrupt
  input wire logic               busy_o         // Busy
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Each error event except data late must land in its own status bits one cycle on
  property p_opi; busy_o && err_i.op_incomplete |=> status_o[10]; endproperty
  a_opi: assert property (p_opi) else $error("opi bit");
  property p_crc; busy_o && (err_i.data_check || err_i.header_check) |=> status_o[11]; endproperty
  a_crc: assert property (p_crc) else $error("crc bit");
  property p_hnf; busy_o && err_i.header_missing |=> status_o[12] && status_o[10]; endproperty
  a_hnf: assert property (p_hnf) else $error("hnf bits");
  property p_nxm; busy_o && err_i.no_memory |=> status_o[13]; endproperty
  a_nxm: assert property (p_nxm) else $error("nxm bit");
  property p_par; busy_o && err_i.parity_abort |=> status_o[13] && status_o[10] && ctrl_ready_o;
  endproperty
  a_par: assert property (p_par) else $error("parity abort");
  property p_drv; busy_o && err_i.drive_err |=> status_o[14]; endproperty
  a_drv: assert property (p_drv) else $error("drive err bit");
  property p_seek; busy_o && seek_sent_i && int_enable_i |=> irq_o && ctrl_ready_o; endproperty
  a_seek: assert property (p_seek) else $error("seek ready");
  // Idle means nothing can interrupt, drive ready rises included
  property p_quiet; !busy_o |=> !irq_o; endproperty
  a_quiet: assert property (p_quiet) else $error("idle irq");
  property p_end; busy_o && xfer_done_i |=> ctrl_ready_o && !busy_o; endproperty
  a_end: assert property (p_end) else $error("end ready");
  property p_hold; !busy_o && !cmd_go_i |=> $stable(status_o); endproperty
  a_hold: assert property (p_hold) else $error("status moved");
  c_seek: cover property (busy_o && seek_sent_i);
  c_par: cover property (busy_o && err_i.parity_abort);
  c_dry: cover property ($rose(drive_ready_o));
endmodule
bind dkc_cmd_status dkc_cmd_status_assertions #(.NDRIVES(NDRIVES)) chk (.*);

// file: test/dkc_drive_model.sv
// Drive-side model: takes seeks, reports them sent, readies later
`timescale 1ns/1ps
module dkc_drive_model (
  input wire logic          clk_i,  // Clock
  input wire logic          go_i,   // Command issue
  input dkc_pkg::dkc_cmd_t  cmd_i,  // Issued command
  output logic              sent_o, // Seek handed over
  output logic [3:0]        rdy_o   // Per-drive ready
);
  int         t [4] = '{0, 0, 0, 0};
  logic [1:0] del   = 2'h0;
  logic       sk;
  initial begin sent_o = 0; rdy_o = 4'hF; end
  assign sk = go_i && cmd_i.func == 3'h3;
  // Long head motion so a second drive starts while the first moves
  always @(posedge clk_i) begin
    del <= {del[0], sk};
    sent_o <= del[1];
    foreach (t[i]) begin
      if (sk && cmd_i.drive == i) begin t[i] <= 20; rdy_o[i] <= 0; end
      else if (t[i] > 1) t[i] <= t[i] - 1;
      else if (t[i] == 1) begin t[i] <= 0; rdy_o[i] <= 1; end
    end
  end
endmodule

// file: test/dkc_cmd_status_tb.sv
// Self-checking bench for the command/error status block
`timescale 1ns/1ps
module dkc_cmd_status_tb;
  logic              clk = 0, rst = 1, go = 0, ie = 1, xd = 0, ss, cr, dr, irq, bsy;
  dkc_pkg::dkc_cmd_t cmd = '0;
  dkc_pkg::dkc_err_t err = '0;
  logic [3:0]        rdy;
  logic [15:0]       st;
  int                fails = 0, check_count = 0;
  // Error event beside expected status bits 15..10
  logic [13:0]       rows [8] = '{14'h2021, 14'h1022, 14'h0822, 14'h0424,
                                  14'h0225, 14'h0128, 14'h00A9, 14'h0070};
  dkc_cmd_status dut (.sys_clk_i(clk), .rst_i(rst), .cmd_go_i(go), .cmd_i(cmd),
    .int_enable_i(ie), .seek_sent_i(ss), .xfer_done_i(xd), .err_i(err), .drv_ready_i(rdy),
    .status_o(st), .ctrl_ready_o(cr), .drive_ready_o(dr), .irq_o(irq), .busy_o(bsy));
  dkc_drive_model drv (.clk_i(clk), .go_i(go), .cmd_i(cmd), .sent_o(ss), .rdy_o(rdy));
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic issue(input logic [2:0] f, input logic [1:0] d);
    @(posedge clk); go <= 1; cmd <= {f, d};
    @(posedge clk); go <= 0;
  endtask
  task automatic pulse(input logic [7:0] e, input logic x);
    @(posedge clk); err <= e; xd <= x;
    @(posedge clk); err <= '0; xd <= 0;
  endtask
  // Bounded wait, then irq and ready must both be up
  task automatic wait_irq;
    int n = 0;
    while (irq !== 1'b1 && n < 10) begin @(posedge clk); #1 n++; end
    check({13'h0, bsy, irq, cr}, 16'h0003);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk); #1 check(st, 16'h0080);
    foreach (rows[i]) begin
      issue(3'h6, 2'h0);
      pulse(rows[i][13:6], 1'b0);
      pulse(8'h00, 1'b1);
      @(posedge clk); #1 check(st, {rows[i][5:0], 10'h080});
    end
    repeat (5) @(posedge clk);
    #1 check(st, 16'hC080);
    issue(3'h3, 2'h0);
    #1 check(st, 16'h0000);
    wait_irq();
    issue(3'h3, 2'h1);
    wait_irq();
    @(posedge clk); #1 check({15'h0, dr}, 16'h0000);
    repeat (30) @(posedge clk);
    #1 check({15'h0, dr, irq}, 16'h0002);
    // Interrupts masked; a seek issued while busy must be refused
    @(posedge clk); ie <= 1'b0;
    issue(3'h6, 2'h2);
    issue(3'h3, 2'h3);
    pulse(8'h00, 1'b1);
    #1 check({13'h0, irq, bsy, cr}, 16'h0001);
    final_report();
  end
  initial begin #20000 fails++; final_report(); end
endmodule
